//--- dv/sd_adc_monitor.sv
// Purpose: Port checker for the converter control block
// Assumes: Bound to sd_adc_ctrl
// Notes:   Writes are counted only with all byte enables set
`timescale 1ns/1ps
module sd_adc_monitor (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic        waitrequest,
    input wire logic [3:0]  pos_input_select,
    input wire logic [3:0]  neg_input_select,
    input wire logic        swap_polarity,
    input wire logic [2:0]  detect_threshold,
    input wire logic [9:0]  dac_a_setting,
    input wire logic [9:0]  dac_b_setting,
    input wire logic        dac_a_on,
    input wire logic        dac_b_on,
    input wire logic        pump_enable,
    input wire logic        pump_clock,
    input wire logic        irq_out
);
    import sd_adc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic        wr;
    logic [2:0]  thr;
    logic [12:0] pc_q;
    logic        pl_q;
    assign wr  = write && !waitrequest && byteenable == 4'hf;
    assign thr = (writedata[10:8] > 3'h4) ? 3'h4 : writedata[10:8];
    always_ff @(posedge clock) begin
        pl_q <= pump_clock;
        if (reset || !pump_enable || pump_clock != pl_q) pc_q <= 13'h0;
        else if (pc_q != 13'h1fff) pc_q <= pc_q + 13'h1;
    end
    property p_wait_first; $rose(read || write) |-> waitrequest; endproperty
    property p_wait_one; (read || write) && waitrequest |=> !waitrequest; endproperty
    property p_dac_a; wr && address == ADDR_DAC_A |=> {dac_a_on, dac_a_setting} == {$past(writedata[15]), $past(writedata[9:0])}; endproperty
    property p_dac_b; wr && address == ADDR_DAC_B |=> {dac_b_on, dac_b_setting} == {$past(writedata[15]), $past(writedata[9:0])}; endproperty
    property p_mux; wr && address == ADDR_MUX |=> {neg_input_select, pos_input_select} == $past(writedata[7:0]); endproperty
    property p_pol; wr && address == ADDR_ADC_CFG |=> swap_polarity == $past(writedata[2]); endproperty
    property p_thr; wr && address == ADDR_INT_CFG |=> detect_threshold == $past(thr); endproperty
    property p_rst_off; $fell(reset) |-> !dac_a_on && !dac_b_on && !pump_enable && !irq_out; endproperty
    property p_pump_half; pump_enable |-> pc_q <= 13'(PUMP_HALF); endproperty
    property p_pump_off; !pump_enable && $past(!pump_enable) |-> !pump_clock; endproperty
    a_wait_first: assert property (p_wait_first) else $error("waitrequest low in first cycle");
    a_wait_one: assert property (p_wait_one) else $error("waitrequest held past one cycle");
    a_dac_a: assert property (p_dac_a) else $error("dac a output mismatch");
    a_dac_b: assert property (p_dac_b) else $error("dac b output mismatch");
    a_mux: assert property (p_mux) else $error("input select mismatch");
    a_pol: assert property (p_pol) else $error("polarity swap mismatch");
    a_thr: assert property (p_thr) else $error("threshold mismatch");
    a_rst_off: assert property (p_rst_off) else $error("outputs active after reset");
    a_pump_half: assert property (p_pump_half) else $error("pump clock half period too long");
    a_pump_off: assert property (p_pump_off) else $error("pump clock runs while disabled");
    c_irq: cover property ($rose(irq_out));
    c_pump: cover property (pump_enable && $changed(pump_clock));
    c_dac: cover property (wr && address == ADDR_DAC_A);
endmodule
bind sd_adc_ctrl sd_adc_monitor u_mon (.clock, .reset, .address, .read, .write, .writedata, .byteenable,
    .waitrequest, .pos_input_select, .neg_input_select, .swap_polarity, .detect_threshold, .dac_a_setting,
    .dac_b_setting, .dac_a_on, .dac_b_on, .pump_enable, .pump_clock, .irq_out);

//--- dv/sd_mod_model.sv
// Purpose: Modulator and comparator stand-in for the converter block
// Assumes: One bit per clock, comparator level from the bench
// Notes:   Mode 0 all low, 1 alternating, 2 all high
`timescale 1ns/1ps
module sd_mod_model (
    input  wire logic       clock,
    input  wire logic [1:0] mode,
    input  wire logic       over,
    output logic            mod_bit,
    output logic            detect_above
);
    logic tog_q;
    initial tog_q = 1'b0;
    always @(posedge clock) tog_q <= !tog_q;
    // Bit density sets the converted level
    assign mod_bit      = (mode == 2'd0) ? 1'b0 : (mode == 2'd1) ? tog_q : 1'b1;
    assign detect_above = over;
endmodule

//--- dv/sigma_delta_adc_control_test.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Short decimation base, Avalon-MM master tasks
// Notes:   Reset and pump expected values come from package constants, the rest are literals
`timescale 1ns/1ps
module sigma_delta_adc_control_test;
    import sd_adc_pkg::*;
    localparam int P = 32;
    logic        clock, reset, read, write, mod_bit, detect_above, det_in, waitrequest;
    logic        swap_polarity, dac_a_on, dac_b_on, pump_enable, pump_clock, irq_out;
    logic [1:0]  mode;
    logic [2:0]  detect_threshold;
    logic [3:0]  byteenable, pos_input_select, neg_input_select, user_io_pin, user_io_pin_oe;
    logic [7:0]  address;
    logic [9:0]  dac_a_setting, dac_b_setting;
    logic [31:0] writedata, readdata, q;
    int          n_mismatch, checks_done, n;
    sd_adc_ctrl #(.DECIM_BASE(P)) uut (.clock, .reset, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .mod_bit, .detect_above, .pos_input_select, .neg_input_select, .swap_polarity,
        .detect_threshold, .dac_a_setting, .dac_b_setting, .dac_a_on, .dac_b_on, .pump_enable, .pump_clock,
        .irq_out, .user_io_pin, .user_io_pin_oe);
    sd_mod_model partner (.clock, .mode, .over(det_in), .mod_bit, .detect_above);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clock);
        address <= a; write <= w; read <= !w; writedata <= d; k = 0;
        do begin @(posedge clock); k++; end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin n_mismatch++; end_of_test(); end
        q = readdata;
        read <= 1'b0; write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(a, 1'b1, d); endtask
    task automatic rd(input logic [7:0] a); bus(a, 1'b0, 32'h0); endtask
    // Cycles until irq_out is high, bounded
    task automatic wait_irq(input int lim);
        n = 0;
        do begin @(posedge clock); n++; end while (irq_out !== 1'b1 && n < lim);
        if (irq_out !== 1'b1) begin n_mismatch++; end_of_test(); end
    endtask
    // Cycles until pump_clock changes, bounded
    task automatic gap();
        logic l;
        l = pump_clock; n = 0;
        while (pump_clock === l && n < 8000) begin @(posedge clock); n++; end
        if (n >= 8000) begin n_mismatch++; end_of_test(); end
    endtask
    task automatic t_reset();
        rd(ADDR_ADC_CFG); chk({24'h0, RST_ADC_CFG}, q);
        rd(ADDR_INT_CFG); chk({21'h0, RST_INT_CFG}, q);
        rd(ADDR_GAIN_CAL); chk({16'h0, RST_GAIN_CAL}, q);
        chk(32'h0, {28'h0, dac_a_on, dac_b_on, pump_enable, irq_out});
        rd(8'h3c); chk(32'h0, q);
    endtask
    task automatic t_regs();
        wr(ADDR_DAC_A, 32'h83ff); wr(ADDR_DAC_B, 32'h8155); @(posedge clock);
        chk({10'h0, 1'b1, 10'h3ff, 1'b1, 10'h155}, {10'h0, dac_a_on, dac_a_setting, dac_b_on, dac_b_setting});
        wr(ADDR_DAC_A, 32'h03ff); @(posedge clock);
        chk(32'h1, {30'h0, dac_a_on, dac_b_on});
        wr(ADDR_MUX, 32'ha5); wr(ADDR_ADC_CFG, 32'h0c); @(posedge clock);
        chk(32'h0b5, {23'h0, pos_input_select, neg_input_select, swap_polarity});
        for (int g = 0; g < 4; g++) begin
            wr(ADDR_ADC_CFG, 32'h8 | g); rd(ADDR_ADC_CFG); chk(32'h8 | g, q);
        end
        for (int v = 0; v < 8; v++) begin
            wr(ADDR_INT_CFG, v << 8); @(posedge clock); chk((v > 4) ? 4 : v, {29'h0, detect_threshold});
        end
        wr(ADDR_INT_CFG, 32'h1);
    endtask
    task automatic t_pump();
        wr(ADDR_SUPPLY, 32'h1); gap(); gap(); chk(PUMP_HALF, n);
        wr(ADDR_SUPPLY, 32'h0); repeat (3) @(posedge clock); chk(32'h0, {31'h0, pump_clock});
    endtask
    task automatic t_conv();
        mode <= 2'd2; wr(ADDR_ADC_CFG, 32'h4); wr(ADDR_STATUS, 32'h7); wr(ADDR_CONV, 32'h0);
        wait_irq(20 * P); chk(32'h1, {31'h0, n >= 4 * P + 1 && n <= 5 * P + 1});
        rd(ADDR_RESULT); chk(32'h0, q);
        rd(ADDR_STATUS); chk(32'h1, {31'h0, q[ST_FAULT]});
        wr(ADDR_STATUS, 32'h7); wait_irq(4 * P); chk(32'h1, {31'h0, n <= P + 1});
        mode <= 2'd1; wr(ADDR_ADC_CFG, 32'h8); wr(ADDR_ZERO_CAL, 32'h10); wr(ADDR_STATUS, 32'h7);
        wr(ADDR_CONV, 32'h0); wait_irq(20 * P);
        rd(ADDR_RESULT); chk(32'h10, q);
        rd(ADDR_STATUS); chk(32'h0, {31'h0, q[ST_FAULT]});
        wr(ADDR_INT_CFG, 32'h31); @(posedge clock);
        chk(32'h6, {29'h0, user_io_pin[2], user_io_pin_oe[2], irq_out});
        wr(ADDR_INT_CFG, 32'h3); @(posedge clock); chk(32'h0, {31'h0, irq_out});
    endtask
    task automatic t_detect();
        wr(ADDR_INT_CFG, 32'h4); wr(ADDR_STATUS, 32'h7); @(posedge clock);
        chk(32'h0, {31'h0, irq_out});
        det_in <= 1'b1; wait_irq(DETECT_CYC); det_in <= 1'b0;
        repeat (20) @(posedge clock); chk(32'h1, {31'h0, irq_out});
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = !clock;
    end
    initial begin
        reset = 1'b1; read = 1'b0; write = 1'b0; address = 8'h0; writedata = 32'h0; byteenable = 4'hf;
        det_in = 1'b0; mode = 2'd1; n_mismatch = 0; checks_done = 0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_reset(); t_regs(); t_pump(); t_conv(); t_detect();
        end_of_test();
    end
endmodule

//--- hw/sd_adc_ctrl.sv
// Purpose: Control and data path of a 16-bit sigma-delta converter
// Assumes: Modulator bit and comparator input from analog side, Avalon-MM slave
// Notes:   Decimation ratio per rate step is DECIM_BASE shifted left by the step
`timescale 1ns/1ps
module sd_adc_ctrl #(
    parameter int DECIM_BASE = 512
) (
    input  wire logic                               clock,
    input  wire logic                               reset,
    input  wire logic [7:0]                         address,
    input  wire logic                               read,
    input  wire logic                               write,
    input  wire logic [31:0]                        writedata,
    input  wire logic [3:0]                         byteenable,
    output logic [31:0]                             readdata,
    output logic                                    waitrequest,
    input  wire logic                               mod_bit,
    input  wire logic                               detect_above,
    output logic [3:0]                              pos_input_select,
    output logic [3:0]                              neg_input_select,
    output logic                                    swap_polarity,
    output logic [2:0]                              detect_threshold,
    output logic [sd_adc_pkg::DAC_BITS-1:0]         dac_a_setting,
    output logic [sd_adc_pkg::DAC_BITS-1:0]         dac_b_setting,
    output logic                                    dac_a_on,
    output logic                                    dac_b_on,
    output logic                                    pump_enable,
    output logic                                    pump_clock,
    output logic                                    irq_out,
    output logic [sd_adc_pkg::N_USER_IO-1:0]        user_io_pin,
    output logic [sd_adc_pkg::N_USER_IO-1:0]        user_io_pin_oe
);
    import sd_adc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           cfg;
        logic [7:0]           mux;
        logic [10:0]          icfg;
        logic [15:0]          zero_cal;
        logic [15:0]          gain_cal;
        logic [15:0]          dac_a;
        logic [15:0]          dac_b;
        logic                 pump_en;
        logic [1:0]           mod_sync;
        logic [1:0]           det_sync;
        logic [ACC_W-1:0]     i1;
        logic [ACC_W-1:0]     i2;
        logic [ACC_W-1:0]     i3;
        logic [ACC_W-1:0]     i4;
        logic [ACC_W-1:0]     c1;
        logic [ACC_W-1:0]     c2;
        logic [ACC_W-1:0]     c3;
        logic [ACC_W-1:0]     c4;
        logic [15:0]          dcnt;
        logic [2:0]           settle;
        logic [RESULT_W-1:0]  result;
        logic                 ready;
        logic                 fault;
        logic                 detect;
        logic [15:0]          det_cnt;
        logic [11:0]          pump_cnt;
        logic                 pump_clk;
        conv_state_t          state;
        logic [31:0]          rdata;
        logic                 ack;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Decimation ratio per rate step: DECIM_BASE at step 0, doubling per step
    function automatic logic [15:0] decim_of(input logic [2:0] rate);
        decim_of = 16'(DECIM_BASE << rate);
    endfunction

    // Normalising shift: sinc4 gain is N^4, bit growth 4*log2(N)
    function automatic logic [5:0] shift_of(input logic [2:0] rate, input logic [1:0] gain);
        logic [5:0] lg;
        lg = 6'($clog2(DECIM_BASE)) + 6'(rate);
        shift_of = 6'(SINC_ORDER) * lg - 6'(RESULT_W - 1) - 6'(gain);
    endfunction

    logic                 sel;
    logic                 bus_req;
    logic [ACC_W-1:0]     filt;
    logic signed [ACC_W-1:0] scaled;
    logic signed [ACC_W-1:0] corr;
    logic signed [ACC_W-1:0] full_max;
    logic signed [ACC_W-1:0] full_min;
    logic                 conv_out;
    logic                 cfg_change;
    logic [15:0]          merged;
    logic                 wr_en;
    logic                 rdy_set;
    logic                 flt_set;
    logic signed [ACC_W-1:0] zero_ext;

    assign bus_req = (read | write) & ~s_q.ack;
    // Writes commit at the edge where waitrequest is sampled low
    assign wr_en   = write & s_q.ack;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        sel = 1'b0;
        filt = '0;
        scaled = '0;
        corr = '0;
        full_max = '0;
        full_min = '0;
        conv_out = 1'b0;
        cfg_change = 1'b0;
        merged = '0;
        rdy_set = 1'b0;
        flt_set = 1'b0;
        zero_ext = '0;
        s_d.ack = bus_req;
        s_d.rdata = '0;

        // Synchronisers
        s_d.mod_sync = {s_q.mod_sync[0], mod_bit};
        s_d.det_sync = {s_q.det_sync[0], detect_above};

        // Sinc4 integrators on +1/-1 bitstream
        sel = s_q.mod_sync[1];
        s_d.i1 = s_q.i1 + (sel ? ACC_W'(1) : {ACC_W{1'b1}});
        s_d.i2 = s_q.i2 + s_q.i1;
        s_d.i3 = s_q.i3 + s_q.i2;
        s_d.i4 = s_q.i4 + s_q.i3;

        // Decimation and comb section
        if (s_q.dcnt == 16'h0001 || s_q.dcnt == 16'h0000) begin
            s_d.dcnt = decim_of(s_q.cfg[CFG_RATE_HI:CFG_RATE_LO]);
            s_d.c1 = s_q.i4;
            s_d.c2 = s_q.i4 - s_q.c1;
            s_d.c3 = (s_q.i4 - s_q.c1) - s_q.c2;
            s_d.c4 = ((s_q.i4 - s_q.c1) - s_q.c2) - s_q.c3;
            filt = (((s_q.i4 - s_q.c1) - s_q.c2) - s_q.c3) - s_q.c4;
            conv_out = 1'b1;
        end else begin
            s_d.dcnt = s_q.dcnt - 16'h0001;
        end

        // Gain, calibration, range handling
        scaled = $signed(filt) >>> shift_of(s_q.cfg[CFG_RATE_HI:CFG_RATE_LO],
                                             s_q.cfg[CFG_GAIN_HI:CFG_GAIN_LO]);
        if (s_q.cfg[CFG_POL]) begin
            scaled = -scaled;
        end
        zero_ext = $signed({{(ACC_W-16){s_q.zero_cal[15]}}, s_q.zero_cal});
        corr = (scaled * $signed({1'b0, s_q.gain_cal})) >>> (RESULT_W - 1);
        if (s_q.cfg[CFG_BIPOLAR]) begin
            full_max = ACC_W'(16'sh7fff);
            full_min = ACC_W'(16'sh8000);
            corr = corr + zero_ext;
        end else begin
            // Unipolar spans zero to reference, so the code step is halved
            full_max = ACC_W'(17'h0ffff);
            full_min = '0;
            corr = (corr <<< 1) + zero_ext;
        end

        if (conv_out) begin
            case (s_q.state)
                ST_IDLE: begin
                    s_d.settle = 3'(SETTLE_PERIODS);
                end
                ST_RUN, ST_HOLD: begin
                    if (s_q.settle != 3'h0) begin
                        s_d.settle = s_q.settle - 3'h1;
                    end
                    // First output taken only after four complete periods
                    if (s_q.settle == 3'h0) begin
                        if (corr > full_max) begin
                            s_d.result = RESULT_W'(full_max);
                            s_d.fault = 1'b1;
                            flt_set = 1'b1;
                        end else if (corr < full_min) begin
                            s_d.result = RESULT_W'(full_min);
                            s_d.fault = 1'b1;
                            flt_set = 1'b1;
                        end else begin
                            s_d.result = RESULT_W'(corr);
                        end
                        s_d.ready = 1'b1;
                        rdy_set = 1'b1;
                        if (s_q.cfg[CFG_SINGLE]) begin
                            s_d.state = ST_HOLD;
                        end
                    end
                end
                default: s_d.state = ST_IDLE;
            endcase
        end
        if (s_q.state == ST_HOLD && s_q.settle == 3'h0) begin
            s_d.state = ST_IDLE;
        end

        // Signal detect with bounded response
        if (s_q.det_sync[1] && s_q.icfg[IC_DET_EN]) begin
            s_d.detect = 1'b1;
        end

        // Charge pump clock: crystal rate halved
        if (s_q.pump_en) begin
            if (s_q.pump_cnt >= 12'(PUMP_HALF - 1)) begin
                s_d.pump_cnt = '0;
                s_d.pump_clk = ~s_q.pump_clk;
            end else begin
                s_d.pump_cnt = s_q.pump_cnt + 12'h001;
            end
        end else begin
            s_d.pump_cnt = '0;
            s_d.pump_clk = 1'b0;
        end

        // ------------------------------------------------------------
        // Register bus
        // ------------------------------------------------------------
        if (wr_en) begin
            merged = writedata[15:0];
            if (address == ADDR_ADC_CFG) begin
                if (byteenable[0]) begin
                    s_d.cfg = writedata[7:0];
                    cfg_change = 1'b1;
                end
            end else if (address == ADDR_MUX) begin
                if (byteenable[0]) begin
                    s_d.mux = writedata[7:0];
                    cfg_change = 1'b1;
                end
            end else if (address == ADDR_STATUS) begin
                // Write one to clear; a new event in the same cycle wins
                if (byteenable[0]) begin
                    if (writedata[ST_READY] && !rdy_set) s_d.ready = 1'b0;
                    if (writedata[ST_FAULT] && !flt_set) s_d.fault = 1'b0;
                    if (writedata[ST_DETECT] && !(s_q.det_sync[1] && s_q.icfg[IC_DET_EN])) s_d.detect = 1'b0;
                end
            end else if (address == ADDR_ZERO_CAL) begin
                if (byteenable[1:0] == 2'b11) s_d.zero_cal = merged;
            end else if (address == ADDR_GAIN_CAL) begin
                if (byteenable[1:0] == 2'b11) s_d.gain_cal = merged;
            end else if (address == ADDR_DAC_A) begin
                if (byteenable[1:0] == 2'b11) s_d.dac_a = merged;
            end else if (address == ADDR_DAC_B) begin
                if (byteenable[1:0] == 2'b11) s_d.dac_b = merged;
            end else if (address == ADDR_SUPPLY) begin
                if (byteenable[0]) s_d.pump_en = writedata[SUP_PUMP_EN];
            end else if (address == ADDR_INT_CFG) begin
                if (byteenable[1:0] == 2'b11) s_d.icfg = writedata[10:0];
            end else if (address == ADDR_CONV) begin
                cfg_change = 1'b1;
            end
        end
        if (cfg_change) begin
            s_d.state = ST_RUN;
            s_d.settle = 3'(SETTLE_PERIODS);
        end

        if (bus_req && read) begin
            if (address == ADDR_ADC_CFG) begin
                s_d.rdata = 32'(s_q.cfg);
            end else if (address == ADDR_MUX) begin
                s_d.rdata = 32'(s_q.mux);
            end else if (address == ADDR_STATUS) begin
                s_d.rdata = 32'({(s_q.settle == 3'h0), s_q.detect, s_q.fault, s_q.ready});
            end else if (address == ADDR_RESULT) begin
                s_d.rdata = 32'(s_q.result);
            end else if (address == ADDR_ZERO_CAL) begin
                s_d.rdata = 32'(s_q.zero_cal);
            end else if (address == ADDR_GAIN_CAL) begin
                s_d.rdata = 32'(s_q.gain_cal);
            end else if (address == ADDR_DAC_A) begin
                s_d.rdata = 32'(s_q.dac_a);
            end else if (address == ADDR_DAC_B) begin
                s_d.rdata = 32'(s_q.dac_b);
            end else if (address == ADDR_SUPPLY) begin
                s_d.rdata = 32'(s_q.pump_en);
            end else if (address == ADDR_INT_CFG) begin
                s_d.rdata = 32'(s_q.icfg);
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
            s_q.cfg <= RST_ADC_CFG;
            s_q.icfg <= RST_INT_CFG;
            s_q.gain_cal <= RST_GAIN_CAL;
            s_q.dac_a <= '0;
            s_q.dac_b <= '0;
            s_q.pump_en <= 1'b0;
            s_q.state <= ST_RUN;
            s_q.settle <= 3'(SETTLE_PERIODS);
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic ready_int;
    logic irq_level;
    logic [2:0] route;

    assign route = s_q.icfg[IC_ROUTE_HI:IC_ROUTE_LO];
    assign ready_int = s_q.ready & s_q.icfg[IC_RDY_EN] & (route == ROUTE_INT);
    assign irq_level = ready_int | s_q.detect;
    assign irq_out = irq_level ^ s_q.icfg[IC_ACT_LOW];

    always_comb begin
        user_io_pin = '0;
        user_io_pin_oe = '0;
        for (int k = 0; k < N_USER_IO; k++) begin
            if (route == 3'(k + 1)) begin
                user_io_pin[k] = s_q.ready;
                user_io_pin_oe[k] = 1'b1;
            end
        end
    end

    assign readdata         = s_q.rdata;
    assign waitrequest      = bus_req;
    assign pos_input_select = s_q.mux[3:0];
    assign neg_input_select = s_q.mux[7:4];
    assign swap_polarity    = s_q.cfg[CFG_POL];
    assign detect_threshold = (s_q.icfg[IC_THR_HI:IC_THR_LO] > 3'(THR_STEPS)) ? 3'(THR_STEPS)
                              : s_q.icfg[IC_THR_HI:IC_THR_LO];
    assign dac_a_setting    = s_q.dac_a[DAC_BITS-1:0];
    assign dac_b_setting    = s_q.dac_b[DAC_BITS-1:0];
    assign dac_a_on         = s_q.dac_a[DAC_EN];
    assign dac_b_on         = s_q.dac_b[DAC_EN];
    assign pump_enable      = s_q.pump_en;
    assign pump_clock       = s_q.pump_clk;
endmodule

//--- hw/sd_adc_pkg.sv
// Purpose: Shared constants for the sigma-delta converter control block
// Assumes: 100 MHz system clock, Avalon-MM register access
// Notes:   Offsets are byte addresses of 32-bit words
package sd_adc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ADC_CFG  = 8'h00;
    localparam logic [7:0] ADDR_MUX      = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_RESULT   = 8'h0c;
    localparam logic [7:0] ADDR_ZERO_CAL = 8'h10;
    localparam logic [7:0] ADDR_GAIN_CAL = 8'h14;
    localparam logic [7:0] ADDR_DAC_A    = 8'h18;
    localparam logic [7:0] ADDR_DAC_B    = 8'h1c;
    localparam logic [7:0] ADDR_SUPPLY   = 8'h20;
    localparam logic [7:0] ADDR_INT_CFG  = 8'h24;
    localparam logic [7:0] ADDR_CONV     = 8'h28;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // adc_cfg: [1:0] gain, [2] swap_polarity, [3] bipolar, [6:4] rate, [7] single
    localparam int CFG_GAIN_LO  = 0;
    localparam int CFG_GAIN_HI  = 1;
    localparam int CFG_POL      = 2;
    localparam int CFG_BIPOLAR  = 3;
    localparam int CFG_RATE_LO  = 4;
    localparam int CFG_RATE_HI  = 6;
    localparam int CFG_SINGLE   = 7;
    // status: [0] conv_ready, [1] range_fault, [2] signal_detect, [3] settled
    localparam int ST_READY     = 0;
    localparam int ST_FAULT     = 1;
    localparam int ST_DETECT    = 2;
    localparam int ST_SETTLED   = 3;
    // dac: [9:0] setting, [15] enable
    localparam int DAC_BITS     = 10;
    localparam int DAC_EN       = 15;
    // supply: [0] pump enable
    localparam int SUP_PUMP_EN  = 0;
    // int_cfg: [0] ready mask, [1] active low, [2] detect mask, [6:4] route, [10:8] threshold
    localparam int IC_RDY_EN    = 0;
    localparam int IC_ACT_LOW   = 1;
    localparam int IC_DET_EN    = 2;
    localparam int IC_ROUTE_LO  = 4;
    localparam int IC_ROUTE_HI  = 6;
    localparam int IC_THR_LO    = 8;
    localparam int IC_THR_HI    = 10;
    localparam logic [2:0] ROUTE_INT = 3'h0;
    localparam int N_USER_IO    = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_ADC_CFG = 8'h08;
    localparam logic [10:0] RST_INT_CFG = 11'h001;
    localparam logic [15:0] RST_GAIN_CAL = 16'h8000;
    // ------------------------------------------------------------
    // Filter and timing
    // ------------------------------------------------------------
    localparam int SINC_ORDER    = 4;
    localparam int SETTLE_PERIODS = 4;
    localparam int ACC_W         = 48;
    localparam int RESULT_W      = 16;
    localparam int CLK_HZ        = 100_000_000;
    localparam int XTAL_HZ       = 32_768;
    localparam int PUMP_HALF     = CLK_HZ / XTAL_HZ;
    localparam int DETECT_US     = 30;
    localparam int DETECT_CYC    = DETECT_US * (CLK_HZ / 1_000_000);
    localparam int NUM_RATES     = 8;
    localparam int MAX_SPS       = 512;
    localparam logic [3:0] THR_STEPS = 4'h4;
    localparam logic [3:0] THR_SHIFT_BASE = 4'h5;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_RUN    = 3'b010,
        ST_HOLD   = 3'b100
    } conv_state_t;
endpackage
